// File: verilog/edge_timer_pkg.sv
/*
  package: register offsets, field positions, reset values and carriers for the
  edge capture and interval timer block.
  assumes: byte-wide register port, one clock domain.
*/
package edge_timer_pkg;
  localparam logic [7:0] free_count_low_addr = 8'h20;
  localparam logic [7:0] free_count_high_addr = 8'h21;
  localparam logic [7:0] chan0_rise_addr = 8'h22;
  localparam logic [7:0] chan1_rise_addr = 8'h23;
  localparam logic [7:0] chan0_fall_addr = 8'h24;
  localparam logic [7:0] chan1_fall_addr = 8'h25;
  localparam logic [7:0] interval_count_low_addr = 8'h26;
  localparam logic [7:0] interval_count_high_addr = 8'h27;
  localparam logic [7:0] interval_reload_low_addr = 8'h28;
  localparam logic [7:0] interval_reload_high_addr = 8'h29;
  localparam logic [7:0] capture_config_addr = 8'h2a;
  localparam logic [7:0] capture_irq_enable_addr = 8'h2b;
  localparam logic [7:0] capture_irq_status_addr = 8'h2c;

  localparam int cfg_hold_bit = 7;
  localparam int cfg_prescale_lsb = 4;
  localparam int cfg_wide_bit = 3;
  localparam logic [7:0] cfg_write_mask = 8'hf8;
  localparam logic [3:0] nibble_mask = 4'hf;
  localparam logic [7:0] byte_zero = 8'h00;
  localparam logic [15:0] count_zero = 16'h0000;
  localparam logic [11:0] interval_zero = 12'h000;
  localparam logic [11:0] interval_one = 12'h001;

  // capture slot indexes; also status/enable bit positions
  localparam int slot_a_rise = 0;
  localparam int slot_a_fall = 1;
  localparam int slot_b_rise = 2;
  localparam int slot_b_fall = 3;
  localparam int slot_count = 4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : edge_timer_pkg

// File: verilog/capture_slot.sv
/*
  one capture register with first-edge hold and software write.
  assumes: load and read strobes are one-cycle pulses on i_core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module capture_slot (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // control
  input wire logic i_hold_mode,
  input wire logic i_load,
  input wire logic [7:0] i_load_value,
  input wire logic i_sw_write,
  input wire logic [7:0] i_sw_value,
  input wire logic i_sw_read,
  // state
  output logic [7:0] o_value,
  output logic o_loaded
);
  logic [7:0] value_r;
  logic locked_r;
  logic take_edge;

  // with hold set, a locked slot ignores edges until read
  assign take_edge = i_load & ~(i_hold_mode & locked_r);
  assign o_value = value_r;
  assign o_loaded = take_edge;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      value_r <= edge_timer_pkg::byte_zero;
      locked_r <= 1'b0;
    end else begin
      if (take_edge) begin
        value_r <= i_load_value;
      end else if (i_sw_write) begin
        value_r <= i_sw_value;
      end
      // a taken edge in the read cycle relocks: the new value is unread
      if (take_edge) begin
        locked_r <= 1'b1;
      end else if (i_sw_read) begin
        locked_r <= 1'b0;
      end
    end
  end
endmodule : capture_slot
`default_nettype wire

// File: verilog/edge_capture_and_interval_timer.sv
/*
  edge capture and interval timer: free-running counter, four capture slots,
  status/enable flags and a 12-bit down-counting interval timer.
  assumes: edge inputs are asynchronous pins; register master per plain port,
  read data valid the cycle after the read strobe.
*/
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module edge_capture_and_interval_timer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // edge inputs
  input wire logic i_edge_input_a,
  input wire logic i_edge_input_b,
  // interrupt requests
  output logic [3:0] o_capture_irq,
  output logic o_interval_irq
);
  edge_timer_pkg::reg_req_t req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // two-stage synchronisers plus one more stage for edge detect
  logic [1:0] sync_a_r;
  logic [1:0] sync_b_r;
  logic prev_a_r;
  logic prev_b_r;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_a_r <= 2'b00;
      prev_a_r <= 1'b0;
    end else begin
      sync_a_r <= {sync_a_r[0], i_edge_input_a};
      prev_a_r <= sync_a_r[1];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync_b_r <= 2'b00;
      prev_b_r <= 1'b0;
    end else begin
      sync_b_r <= {sync_b_r[0], i_edge_input_b};
      prev_b_r <= sync_b_r[1];
    end
  end
  wire logic rise_a = sync_a_r[1] & ~prev_a_r;
  wire logic fall_a = ~sync_a_r[1] & prev_a_r;
  wire logic rise_b = sync_b_r[1] & ~prev_b_r;
  wire logic fall_b = ~sync_b_r[1] & prev_b_r;

  // address decode
  wire logic hit_free_low = req.addr == edge_timer_pkg::free_count_low_addr;
  wire logic hit_free_high = req.addr == edge_timer_pkg::free_count_high_addr;
  wire logic hit_a_rise = req.addr == edge_timer_pkg::chan0_rise_addr;
  wire logic hit_b_rise = req.addr == edge_timer_pkg::chan1_rise_addr;
  wire logic hit_a_fall = req.addr == edge_timer_pkg::chan0_fall_addr;
  wire logic hit_b_fall = req.addr == edge_timer_pkg::chan1_fall_addr;
  wire logic hit_cnt_low = req.addr == edge_timer_pkg::interval_count_low_addr;
  wire logic hit_cnt_high = req.addr == edge_timer_pkg::interval_count_high_addr;
  wire logic hit_rld_low = req.addr == edge_timer_pkg::interval_reload_low_addr;
  wire logic hit_rld_high = req.addr == edge_timer_pkg::interval_reload_high_addr;
  wire logic hit_cfg = req.addr == edge_timer_pkg::capture_config_addr;
  wire logic hit_ien = req.addr == edge_timer_pkg::capture_irq_enable_addr;
  wire logic hit_sts = req.addr == edge_timer_pkg::capture_irq_status_addr;

  // write and read strobes per register
  wire logic wr_free_low = req.wr & hit_free_low;
  wire logic wr_free_high = req.wr & hit_free_high;
  wire logic rd_free_low = req.rd & hit_free_low;
  wire logic rd_cnt_low = req.rd & hit_cnt_low;
  wire logic wr_rld_low = req.wr & hit_rld_low;
  wire logic wr_rld_high = req.wr & hit_rld_high;
  wire logic wr_cfg = req.wr & hit_cfg;
  wire logic wr_ien = req.wr & hit_ien;
  wire logic wr_sts = req.wr & hit_sts;

  // configuration and enables
  logic [7:0] config_r;
  logic [3:0] irq_enable_r;
  logic [3:0] irq_status_r;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      config_r <= edge_timer_pkg::byte_zero;
    end else if (wr_cfg) begin
      config_r <= req.wdata & edge_timer_pkg::cfg_write_mask;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_enable_r <= 4'h0;
    end else if (wr_ien) begin
      irq_enable_r <= req.wdata[3:0];
    end
  end
  wire logic hold_mode = config_r[edge_timer_pkg::cfg_hold_bit];
  wire logic wide_mode = config_r[edge_timer_pkg::cfg_wide_bit];
  wire logic [2:0] prescale = config_r[edge_timer_pkg::cfg_prescale_lsb +: 3];

  // free-running counter with low-read holding of the high byte
  logic [15:0] free_count_r;
  logic [7:0] free_high_hold_r;
  logic [7:0] free_low_pend_r;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      free_count_r <= edge_timer_pkg::count_zero;
    end else if (wr_free_high) begin
      free_count_r <= {req.wdata, free_low_pend_r};
    end else begin
      free_count_r <= free_count_r + 16'h0001;
    end
  end

  // a counter write lands with the high byte, so both halves change together
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      free_low_pend_r <= edge_timer_pkg::byte_zero;
    end else if (wr_free_low) begin
      free_low_pend_r <= req.wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      free_high_hold_r <= edge_timer_pkg::byte_zero;
    end else if (rd_free_low) begin
      free_high_hold_r <= free_count_r[15:8];
    end
  end

  // prescaled byte window
  wire logic [15:0] shifted_count = free_count_r >> prescale;
  wire logic [7:0] narrow_value = shifted_count[7:0];

  // slot load values and strobes
  logic [3:0] slot_load;
  logic [7:0] slot_load_value [edge_timer_pkg::slot_count];
  logic [3:0] slot_sw_write;
  logic [3:0] slot_sw_read;
  logic [7:0] slot_value [edge_timer_pkg::slot_count];
  logic [3:0] slot_loaded;

  // channel a uses the low byte in wide mode
  assign slot_load[edge_timer_pkg::slot_a_rise] = rise_a;
  assign slot_load[edge_timer_pkg::slot_a_fall] = fall_a;
  // channel b is driven by channel a edges in wide mode
  assign slot_load[edge_timer_pkg::slot_b_rise] = wide_mode ? rise_a : rise_b;
  assign slot_load[edge_timer_pkg::slot_b_fall] = wide_mode ? fall_a : fall_b;
  assign slot_load_value[edge_timer_pkg::slot_a_rise] = wide_mode ? free_count_r[7:0] : narrow_value;
  assign slot_load_value[edge_timer_pkg::slot_a_fall] = wide_mode ? free_count_r[7:0] : narrow_value;
  assign slot_load_value[edge_timer_pkg::slot_b_rise] = wide_mode ? free_count_r[15:8] : narrow_value;
  assign slot_load_value[edge_timer_pkg::slot_b_fall] = wide_mode ? free_count_r[15:8] : narrow_value;

  assign slot_sw_write = {4{req.wr}} & {hit_b_fall, hit_b_rise, hit_a_fall, hit_a_rise};
  assign slot_sw_read = {4{req.rd}} & {hit_b_fall, hit_b_rise, hit_a_fall, hit_a_rise};

  // four capture registers, one per channel and edge
  genvar g;
  generate
    for (g = 0; g < edge_timer_pkg::slot_count; g++) begin : g_slot
      capture_slot u_slot (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_hold_mode(hold_mode),
        .i_load(slot_load[g]),
        .i_load_value(slot_load_value[g]),
        .i_sw_write(slot_sw_write[g]),
        .i_sw_value(req.wdata),
        .i_sw_read(slot_sw_read[g]),
        .o_value(slot_value[g]),
        .o_loaded(slot_loaded[g])
      );
    end
  endgenerate

  // status flags: edge events set, write-one clears; set wins
  wire logic [3:0] edge_events = {fall_b, rise_b, fall_a, rise_a};
  wire logic [3:0] status_clear = wr_sts ? req.wdata[3:0] : 4'h0;
  wire logic [3:0] status_nxt = edge_events | (irq_status_r & ~status_clear);
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      irq_status_r <= 4'h0;
    end else begin
      irq_status_r <= status_nxt;
    end
  end

  // a request only when a slot loads and its flag was clear
  logic [3:0] capture_irq_r;
  wire logic [3:0] capture_irq_nxt = slot_loaded & irq_enable_r & ~irq_status_r;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      capture_irq_r <= 4'h0;
    end else begin
      capture_irq_r <= capture_irq_nxt;
    end
  end
  assign o_capture_irq = capture_irq_r;

  // interval timer
  logic [11:0] interval_count_r;
  logic [11:0] interval_reload_r;
  logic [3:0] interval_high_hold_r;
  logic interval_irq_r;
  wire logic interval_expire = interval_count_r <= edge_timer_pkg::interval_one;
  wire logic [11:0] interval_count_nxt = interval_expire ? interval_reload_r :
    interval_count_r - edge_timer_pkg::interval_one;
  // low then high is the expected order; each half lands on its own
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      interval_reload_r <= edge_timer_pkg::interval_zero;
    end else begin
      if (wr_rld_low) begin
        interval_reload_r[7:0] <= req.wdata;
      end
      if (wr_rld_high) begin
        interval_reload_r[11:8] <= req.wdata[3:0] & edge_timer_pkg::nibble_mask;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      interval_count_r <= edge_timer_pkg::interval_zero;
    end else begin
      interval_count_r <= interval_count_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      interval_irq_r <= 1'b0;
    end else begin
      interval_irq_r <= interval_expire;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      interval_high_hold_r <= 4'h0;
    end else if (rd_cnt_low) begin
      interval_high_hold_r <= interval_count_r[11:8];
    end
  end
  assign o_interval_irq = interval_irq_r;

  // read mux
  logic [7:0] read_mux;
  always_comb begin
    read_mux = edge_timer_pkg::byte_zero;
    case (1'b1)
      hit_free_low: read_mux = free_count_r[7:0];
      hit_free_high: read_mux = free_high_hold_r;
      hit_a_rise: read_mux = slot_value[edge_timer_pkg::slot_a_rise];
      hit_b_rise: read_mux = slot_value[edge_timer_pkg::slot_b_rise];
      hit_a_fall: read_mux = slot_value[edge_timer_pkg::slot_a_fall];
      hit_b_fall: read_mux = slot_value[edge_timer_pkg::slot_b_fall];
      hit_cnt_low: read_mux = interval_count_r[7:0];
      hit_cnt_high: read_mux = {4'h0, interval_high_hold_r};
      hit_rld_low: read_mux = interval_reload_r[7:0];
      hit_rld_high: read_mux = {4'h0, interval_reload_r[11:8]};
      hit_cfg: read_mux = config_r;
      hit_ien: read_mux = {4'h0, irq_enable_r};
      hit_sts: read_mux = {4'h0, irq_status_r};
      default: read_mux = edge_timer_pkg::byte_zero;
    endcase
  end

  logic [7:0] rdata_r;
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rdata_r <= edge_timer_pkg::byte_zero;
    end else if (req.rd) begin
      rdata_r <= read_mux;
    end else begin
      rdata_r <= edge_timer_pkg::byte_zero;
    end
  end
  assign o_rdata = rdata_r;
endmodule : edge_capture_and_interval_timer
`default_nettype wire

// File: sim/edge_pin_model.sv
/* far side: two digital edge sources on the capture inputs.
   assumes: bench asks for a toggle with a one-cycle pulse per pin. */
`timescale 1ns/10ps
`default_nettype none
module edge_pin_model (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // bench commands
  input wire logic [1:0] i_toggle,
  input wire logic i_slow,
  // pin levels
  output logic [1:0] o_pins
);
  logic [1:0] pend_r;
  // slow answer delays the change one cycle to move the capture moment
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pend_r <= 2'b00;
      o_pins <= 2'b00;
    end else begin
      pend_r <= i_slow ? i_toggle : 2'b00;
      o_pins <= o_pins ^ (i_slow ? pend_r : i_toggle);
    end
  end
endmodule : edge_pin_model
`default_nettype wire

// File: sim/edge_capture_and_interval_timer_properties.sv
/* checker for the edge capture and interval timer ports.
   assumes: bound to the top module, one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module edge_timer_properties (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // edge inputs
  input wire logic i_edge_input_a,
  input wire logic i_edge_input_b,
  // interrupt requests
  input wire logic [3:0] o_capture_irq,
  input wire logic o_interval_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic [11:0] reload_r, count_r;
  logic [7:0] config_r;
  logic [3:0] hold_r, enable_r;
  logic expire_r;
  // mirror of the down counter, so reads can be checked exactly
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      reload_r <= 12'h000;
      count_r <= 12'h000;
      config_r <= 8'h00;
      hold_r <= 4'h0;
      enable_r <= 4'h0;
      expire_r <= 1'b0;
    end else begin
      count_r <= (count_r <= 12'h001) ? reload_r : count_r - 12'h001;
      expire_r <= (count_r <= 12'h001);
      if (i_rd && i_addr == 8'h26) hold_r <= count_r[11:8];
      if (i_wr && i_addr == 8'h28) reload_r[7:0] <= i_wdata;
      if (i_wr && i_addr == 8'h29) reload_r[11:8] <= i_wdata[3:0];
      if (i_wr && i_addr == 8'h2a) config_r <= i_wdata & 8'hf8;
      if (i_wr && i_addr == 8'h2b) enable_r <= i_wdata[3:0];
    end
  end
  sequence count_pair_s;
    i_rd && i_addr == 8'h26 ##1 i_rd && i_addr == 8'h27;
  endsequence
  count_low_read_a: assert property (i_rd && i_addr == 8'h26 |=> o_rdata == 8'($past(count_r)))
    else $error("interval low byte read wrong");
  count_high_hold_a: assert property (count_pair_s |=> o_rdata == {4'h0, hold_r})
    else $error("interval high nibble read wrong");
  interval_expiry_a: assert property (o_interval_irq == expire_r)
    else $error("interval expiry pulse wrong");
  reload_read_a: assert property (i_rd && i_addr == 8'h28 |=> o_rdata == 8'($past(reload_r)))
    else $error("reload low read wrong");
  config_read_a: assert property (i_rd && i_addr == 8'h2a |=> o_rdata == $past(config_r))
    else $error("config read wrong");
  enable_read_a: assert property (i_rd && i_addr == 8'h2b |=> o_rdata == {4'h0, $past(enable_r)})
    else $error("irq enable read wrong");
  unmapped_read_a: assert property (i_rd && (i_addr < 8'h20 || i_addr > 8'h2c) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  status_upper_a: assert property (i_rd && i_addr == 8'h2c |=> o_rdata[7:4] == 4'h0)
    else $error("status reserved bits set");
  irq_gated_a: assert property ((o_capture_irq & ~$past(enable_r)) == 4'h0)
    else $error("capture irq while disabled");
  irq_single_a: assert property ((o_capture_irq & $past(o_capture_irq)) == 4'h0)
    else $error("capture irq repeated");
endmodule : edge_timer_properties
bind edge_capture_and_interval_timer edge_timer_properties i_edge_timer_properties (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_edge_input_a(i_edge_input_a), .i_edge_input_b(i_edge_input_b),
  .o_capture_irq(o_capture_irq), .o_interval_irq(o_interval_irq));
`default_nettype wire

// File: sim/test_edge_capture_and_interval_timer.sv
/* self-checking bench for the edge capture and interval timer.
   assumes: package, design, pin model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module test_edge_capture_and_interval_timer;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  edge_timer_pkg::reg_req_t req = '0;
  logic [7:0] o_rdata;
  logic [3:0] o_capture_irq;
  logic o_interval_irq;
  logic [1:0] pins;
  logic [1:0] tgl = 2'b00;
  logic slow = 1'b0;
  logic [31:0] rnd = 32'he96a;
  logic [15:0] f;
  logic [11:0] rl;
  logic [7:0] got;
  logic [2:0] n;
  int err_count = 0;
  int n_tests = 0;
  int irq_cnt [4] = '{default: 0};
  int base;
  always #2 i_core_clk = ~i_core_clk;
  edge_capture_and_interval_timer i_edge_capture_and_interval_timer (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .i_addr(req.addr), .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd),
    .o_rdata(o_rdata), .i_edge_input_a(pins[0]), .i_edge_input_b(pins[1]),
    .o_capture_irq(o_capture_irq), .o_interval_irq(o_interval_irq));
  edge_pin_model i_edge_pin_model (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_toggle(tgl),
    .i_slow(slow), .o_pins(pins));
  always @(posedge i_core_clk) begin
    for (int j = 0; j < 4; j++) begin
      if (o_capture_irq[j] === 1'b1) irq_cnt[j]++;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] window(input logic [15:0] v, input logic [2:0] s);
    return 8'(v >> s);
  endfunction : window
  function automatic logic [7:0] slot(input int s);
    return 8'h22 + {6'h00, s[0], s[1]};
  endfunction : slot
  task automatic roll();
    repeat (32) rnd = lfsr(rnd);
  endtask : roll
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    req.wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    req.rd <= 1'b0;
    @(posedge i_core_clk);
    chk(what, o_rdata, exp);
  endtask : rchk
  // counter low bits start aligned, so a few cycles of sync delay stay in one window
  task automatic fire(input int s, input logic [15:0] v);
    wr(8'h20, v[7:0]);
    wr(8'h21, v[15:8]);
    tgl <= 2'(1 << s[1]);
    slow <= rnd[8];
    @(posedge i_core_clk);
    tgl <= 2'b00;
    repeat (9) @(posedge i_core_clk);
  endtask : fire
  task automatic summarize();
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (50000) @(posedge i_core_clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    for (int a = 'h22; a <= 'h2c; a++) if (a < 'h26 || a > 'h27) rchk("reset", 8'(a), 8'h00);
    wr(8'h31, 8'hff);
    rchk("unmapped", 8'h31, 8'h00);
    repeat (3) begin
      roll();
      wr(8'h2a, rnd[7:0]);
      rchk("config", 8'h2a, rnd[7:0] & 8'hf8);
      wr(8'h2b, rnd[15:8]);
      rchk("enable", 8'h2b, {4'h0, rnd[11:8]});
      wr(8'h28, rnd[23:16]);
      wr(8'h29, rnd[31:24]);
      rchk("reload low", 8'h28, rnd[23:16]);
      rchk("reload high", 8'h29, {4'h0, rnd[27:24]});
    end
    roll();
    rl = rnd[11:0] | 12'h100;
    wr(8'h28, rl[7:0]);
    wr(8'h29, {4'h0, rl[11:8]});
    @(posedge i_core_clk);
    for (int i = 0; i < 10000 && o_interval_irq !== 1'b1; i++) @(posedge i_core_clk);
    chk("interval expiry", {7'h00, o_interval_irq}, 8'h01);
    req <= '{addr: 8'h26, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    req.addr <= 8'h27;
    @(posedge i_core_clk);
    got = o_rdata;
    req.rd <= 1'b0;
    @(posedge i_core_clk);
    chk("count low", got, 8'(rl - 12'h001));
    chk("count high", o_rdata, {4'h0, 4'((rl - 12'h001) >> 8)});
    for (int s = 0; s < 4; s++) begin
      roll();
      n = 3'h4 | rnd[2:0];
      f = rnd[31:16] & (16'hffff << n);
      wr(8'h2a, {1'b0, n, 4'h0});
      wr(8'h2b, {4'h0, rnd[7:4]});
      wr(slot(s), rnd[15:8]);
      rchk("slot write", slot(s), rnd[15:8]);
      base = irq_cnt[s];
      fire(s, f);
      rchk("capture", slot(s), window(f, n));
      chk("capture irq", 8'(irq_cnt[s] - base), {7'h00, rnd[4 + s]});
      wr(8'h2c, 8'h00);
      rchk("status kept", 8'h2c, 8'(1 << s));
      wr(8'h2c, 8'(1 << s));
      rchk("status cleared", 8'h2c, 8'h00);
    end
    for (int h = 0; h < 2; h++) begin
      roll();
      f = {rnd[15:4], 4'h0};
      wr(8'h2a, {h[0], 3'h4, 4'h0});
      fire(0, f);
      fire(0, f ^ 16'h0800);
      fire(0, f ^ 16'h0800);
      rchk("edge hold", 8'h22, window(h[0] ? f : f ^ 16'h0800, 3'h4));
      fire(0, f);
      fire(0, f ^ 16'h0300);
      rchk("after read", 8'h22, window(f ^ 16'h0300, 3'h4));
      fire(0, f);
    end
    wr(8'h2c, 8'h0f);
    roll();
    f = {rnd[7:0], 8'h00};
    wr(8'h2a, 8'h08);
    fire(0, f);
    rchk("wide rise high", 8'h23, f[15:8]);
    fire(0, f ^ 16'h5500);
    rchk("wide fall high", 8'h25, f[15:8] ^ 8'h55);
    fire(2, 16'h0000);
    rchk("b ignored", 8'h23, f[15:8]);
    rchk("wide status", 8'h2c, 8'h07);
    summarize();
  end
endmodule : test_edge_capture_and_interval_timer
`default_nettype wire
